// >>> hdl/rvg_map.vh
`ifndef RVG_MAP_VH
`define RVG_MAP_VH
`define RVG_ADDR_W 16
`define RVG_NUM_SRC 34
`define RVG_RESET_BASE 16'h0000
`define RVG_FIRST_VEC 16'h0002
`define RVG_VEC_STEP 16'h0002
`define RVG_BOOT_START 16'hf000
`define RVG_FUSE_PROGRAMMED 1'b0
`endif

// >>> hdl/rvg_prio_enc.v
`timescale 1ns/1ps
// lowest index wins among pending requests
module rvg_prio_enc #(
	parameter N = 34,
	parameter W = 6
) (
	input wire [N-1:0] request,
	output reg found,
	output reg [W-1:0] index
);
	integer i;
	always @* begin
		found = 1'b0;
		index = {W{1'b0}};
		for (i = N - 1; i >= 0; i = i - 1) begin
			if (request[i]) begin
				found = 1'b1;
				index = i[W-1:0];
			end
		end
	end
endmodule

// >>> hdl/rvg_vector_gen.v
`timescale 1ns/1ps
// Notes on behaviour
// - every reset cause uses vector 1, base word 0x0000
// - external requests 0..2 at words 0x0002, 0x0004, 0x0006
// - pin change requests 0..3 at 0x0008 to 0x000e, step two
// - watchdog 0x0010; timer2 match a, match b, overflow 0x0012..0x0016
// - timer1 capture, match a, match b, overflow at 0x0018..0x001e
// - timer0 match a, match b, overflow at 0x0020..0x0024
// - spi done at 0x0026, vector 20
// - serial0 rx done, tx empty, tx done at 0x0028..0x002c
// - comparator, converter, eeprom, two-wire, self-program at 0x002e..0x0036
// - serial1 rx done, tx empty, tx done at 0x0038..0x003c
// - timer3 capture, match a, match b, overflow at 0x003e..0x0044
// - programmed boot fuse moves the reset entry to boot start
// - relocation bit adds boot start to every interrupt vector
// - fuse low means programmed; vectors ignore the fuse
`include "rvg_map.vh"
module rvg_vector_gen #(
	parameter ADDR_W = `RVG_ADDR_W,
	parameter NUM_SRC = `RVG_NUM_SRC,
	parameter [ADDR_W-1:0] BOOT_START = `RVG_BOOT_START
) (
	input wire clock,
	input wire rst_n,
	input wire boot_reset_fuse,
	input wire vector_relocate_bit,
	input wire ext_request_0,
	input wire ext_request_1,
	input wire ext_request_2,
	input wire pin_change_request_0,
	input wire pin_change_request_1,
	input wire pin_change_request_2,
	input wire pin_change_request_3,
	input wire watchdog_timeout_request,
	input wire timer2_match_a_request,
	input wire timer2_match_b_request,
	input wire timer2_overflow_request,
	input wire timer1_capture_request,
	input wire timer1_match_a_request,
	input wire timer1_match_b_request,
	input wire timer1_overflow_request,
	input wire timer0_match_a_request,
	input wire timer0_match_b_request,
	input wire timer0_overflow_request,
	input wire spi_done_request,
	input wire serial0_rx_done_request,
	input wire serial0_tx_empty_request,
	input wire serial0_tx_done_request,
	input wire comparator_request,
	input wire converter_done_request,
	input wire eeprom_ready_request,
	input wire two_wire_request,
	input wire self_program_ready_request,
	input wire serial1_rx_done_request,
	input wire serial1_tx_empty_request,
	input wire serial1_tx_done_request,
	input wire timer3_capture_request,
	input wire timer3_match_a_request,
	input wire timer3_match_b_request,
	input wire timer3_overflow_request,
	output reg [ADDR_W-1:0] reset_address,
	output reg irq_pending,
	output reg [5:0] irq_vector_number,
	output reg [ADDR_W-1:0] irq_vector_address
);
	wire [NUM_SRC-1:0] request;
	wire found;
	wire [5:0] index;
	reg [ADDR_W-1:0] next_reset_address;
	reg [ADDR_W-1:0] next_irq_vector_address;
	reg [5:0] next_irq_vector_number;

	// bit order is table order, so bit i is vector number i+2
	assign request = {
		timer3_overflow_request, timer3_match_b_request, timer3_match_a_request, timer3_capture_request,
		serial1_tx_done_request, serial1_tx_empty_request, serial1_rx_done_request,
		self_program_ready_request, two_wire_request, eeprom_ready_request, converter_done_request,
		comparator_request,
		serial0_tx_done_request, serial0_tx_empty_request, serial0_rx_done_request,
		spi_done_request,
		timer0_overflow_request, timer0_match_b_request, timer0_match_a_request,
		timer1_overflow_request, timer1_match_b_request, timer1_match_a_request, timer1_capture_request,
		timer2_overflow_request, timer2_match_b_request, timer2_match_a_request, watchdog_timeout_request,
		pin_change_request_3, pin_change_request_2, pin_change_request_1, pin_change_request_0,
		ext_request_2, ext_request_1, ext_request_0
	};

	rvg_prio_enc #(
		.N(NUM_SRC),
		.W(6)
	) u_prio (
		.request(request),
		.found(found),
		.index(index)
	);

	// base table slot: first vector plus two words per index
	function [ADDR_W-1:0] slot_address;
		input [5:0] idx;
		begin
			slot_address = `RVG_FIRST_VEC + {{(ADDR_W-7){1'b0}}, idx, 1'b0};
		end
	endfunction

	always @* begin
		if (boot_reset_fuse == `RVG_FUSE_PROGRAMMED) begin
			next_reset_address = BOOT_START;
		end else begin
			next_reset_address = `RVG_RESET_BASE;
		end
		// relocation ignores the fuse on purpose
		if (vector_relocate_bit) begin
			next_irq_vector_address = slot_address(index) + BOOT_START;
		end else begin
			next_irq_vector_address = slot_address(index);
		end
		next_irq_vector_number = index + 6'h02;
	end

	// registered so the core fetch sees stable values; one cycle of latency
	always @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reset_address <= `RVG_RESET_BASE;
			irq_pending <= 1'b0;
			irq_vector_number <= 6'h00;
			irq_vector_address <= `RVG_FIRST_VEC;
		end else begin
			reset_address <= next_reset_address;
			irq_pending <= found;
			irq_vector_number <= found ? next_irq_vector_number : 6'h00;
			irq_vector_address <= next_irq_vector_address;
		end
	end
endmodule

// >>> verif/rvg_chk_sva.sv
`timescale 1ns/1ps
module rvg_chk(
	input logic clock,
	input logic rst_n,
	input logic boot_reset_fuse,
	input logic vector_relocate_bit,
	input logic [15:0] reset_address,
	input logic irq_pending,
	input logic [5:0] irq_vector_number,
	input logic [15:0] irq_vector_address
);
logic up;
// outputs trail inputs by one edge, so skip the first edge after reset
always_ff @(posedge clock or negedge rst_n) begin
	if (!rst_n) up <= 1'b0;
	else up <= 1'b1;
end
default clocking @(posedge clock); endclocking
default disable iff (!rst_n);
property p_rst; up |-> reset_address == ($past(boot_reset_fuse) ? 16'h0 : 16'hf000); endproperty
a_rst: assert property (p_rst) else $error("reset entry");
property p_adr; up && irq_pending |-> irq_vector_address == 2*irq_vector_number-2+($past(vector_relocate_bit)?16'hf000:0); endproperty
a_adr: assert property (p_adr) else $error("vector address");
property p_lo; up && !$past(vector_relocate_bit) |-> irq_vector_address < 16'h46; endproperty
a_lo: assert property (p_lo) else $error("low table");
property p_hi; up && $past(vector_relocate_bit) |-> irq_vector_address > 16'hf001; endproperty
a_hi: assert property (p_hi) else $error("boot table");
property p_idl; !irq_pending |-> irq_vector_number == 6'h0; endproperty
a_idl: assert property (p_idl) else $error("idle number");
property p_rng; irq_pending |-> irq_vector_number inside {[2:35]}; endproperty
a_rng: assert property (p_rng) else $error("number range");
property p_fus; up && $changed(boot_reset_fuse) |=> $changed(reset_address); endproperty
a_fus: assert property (p_fus) else $error("fuse ignored");
property p_rel; $rose(vector_relocate_bit) |=> irq_vector_address[15:12] == 4'hf; endproperty
a_rel: assert property (p_rel) else $error("relocation late");
endmodule
bind rvg_vector_gen rvg_chk u_chk(.*);

// >>> verif/rvg_src.sv
`timescale 1ns/1ps
module rvg_src(
	input logic clock,
	output logic [33:0] q = 34'h0,
	output logic f = 1'b1,
	output logic v = 1'b0
);
// levels change just after an edge and stand for one whole cycle
task put(input [33:0] r, input a, b);
	{q, f, v} = {r, a, b};
	@(posedge clock);
	#1;
endtask
endmodule

// >>> verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
logic clock = 0;
logic rst_n = 0;
wire [33:0] q;
wire f, v, p;
wire [15:0] ra, va;
wire [5:0] n;
int bad_count, checks;
rvg_src m(.clock(clock), .q(q), .f(f), .v(v));
rvg_vector_gen DUT(.clock(clock), .rst_n(rst_n), .boot_reset_fuse(f), .vector_relocate_bit(v),
	.ext_request_0(q[0]), .ext_request_1(q[1]), .ext_request_2(q[2]), .pin_change_request_0(q[3]),
	.pin_change_request_1(q[4]), .pin_change_request_2(q[5]), .pin_change_request_3(q[6]),
	.watchdog_timeout_request(q[7]), .timer2_match_a_request(q[8]), .timer2_match_b_request(q[9]),
	.timer2_overflow_request(q[10]), .timer1_capture_request(q[11]), .timer1_match_a_request(q[12]),
	.timer1_match_b_request(q[13]), .timer1_overflow_request(q[14]), .timer0_match_a_request(q[15]),
	.timer0_match_b_request(q[16]), .timer0_overflow_request(q[17]), .spi_done_request(q[18]),
	.serial0_rx_done_request(q[19]), .serial0_tx_empty_request(q[20]), .serial0_tx_done_request(q[21]),
	.comparator_request(q[22]), .converter_done_request(q[23]), .eeprom_ready_request(q[24]),
	.two_wire_request(q[25]), .self_program_ready_request(q[26]), .serial1_rx_done_request(q[27]),
	.serial1_tx_empty_request(q[28]), .serial1_tx_done_request(q[29]), .timer3_capture_request(q[30]),
	.timer3_match_a_request(q[31]), .timer3_match_b_request(q[32]), .timer3_overflow_request(q[33]),
	.reset_address(ra), .irq_pending(p), .irq_vector_number(n), .irq_vector_address(va));
initial forever #20 clock = ~clock;
task c(input [15:0] g, e);
	checks++;
	if (g !== e) begin
		bad_count++;
		$display("ERROR %0t got %h want %h", $time, g, e);
	end
endtask
// each lower source masks all above it, so one sweep covers map and priority
task t_map(input b);
	for (int i = 0; i < 34; i++) begin
		m.put(~34'h0 << i, 1, b);
		c(p, 1);
		c(n, i + 2);
		c(va, 2 * i + 2 + (b ? 16'hf000 : 0));
	end
endtask
task t_boot;
	for (int i = 0; i < 2; i++) begin
		m.put(0, i, 1);
		c(ra, i ? 16'h0 : 16'hf000);
		c(p, 0);
	end
endtask
// mid-run reset with requests still high: outputs clear at once, no false request after
task t_rst;
	rst_n = 0;
	#1;
	c(ra, 16'h0000);
	c(p, 0);
	c(n, 0);
	c(va, 16'h0002);
	@(posedge clock);
	#1;
	rst_n = 1;
	m.put(0, 1, 0);
	c(p, 0);
	c(va, 16'h0002);
	c(ra, 16'h0000);
endtask
task results;
	$display("%0d checks %0d errors", checks, bad_count);
	if (bad_count == 0 && checks > 0) $display("Run complete: PASS");
	else $display("Run complete: FAIL");
	$finish;
endtask
initial begin
	repeat (16) @(posedge clock);
	#1;
	rst_n = 1;
	t_boot;
	t_map(0);
	t_map(1);
	t_rst;
	t_map(0);
	results;
end
initial begin
	#100000;
	bad_count++;
	results;
end
endmodule
